// File: tss_pkg.sv
// package for the tdm slot strobe and channel select block
// assumes a 12 slot, 8 bit per slot backplane frame, msb first
package tss_pkg;
  localparam int SLOTS_PER_FRAME = 12;
  localparam int SLOT_W          = 4;
  localparam int BIT_W           = 3;
  localparam int CNT_W           = 7;
  localparam int ADDR_W          = 4;
  localparam int DATA_W          = 8;
  localparam logic [CNT_W-1:0]  FRAME_LAST   = 7'h5F;
  localparam logic [BIT_W-1:0]  BIT_LAST     = 3'h7;
  localparam logic [SLOT_W-1:0] NEXT_OFS     = 4'h1;
  localparam logic [SLOT_W-1:0] THIRD_OFS    = 4'h3;
  localparam logic [BIT_W-1:0]  THIRD_BITS   = 3'h2;
  localparam logic [SLOT_W-1:0] LOAD_GAP     = 4'h2;
  localparam logic [SLOT_W-1:0] MON_IN_CH    = 4'h2;
  localparam logic [SLOT_W-1:0] SLOTS_PER_CH = 4'h4;
  // register offsets
  localparam logic [ADDR_W-1:0] REG_MODE     = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STR_A    = 4'h1;
  localparam logic [ADDR_W-1:0] REG_STR_B    = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STR_CONF = 4'h3;
  localparam logic [ADDR_W-1:0] REG_MON_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] REG_MON_DATA = 4'h5;
  localparam logic [ADDR_W-1:0] REG_MOVE_SRC = 4'h6;
  localparam logic [ADDR_W-1:0] REG_MOVE_DST = 4'h7;
  localparam logic [ADDR_W-1:0] REG_ACCESS   = 4'h8;
  localparam logic [ADDR_W-1:0] REG_POSITION = 4'h9;
  // reset values
  localparam logic [DATA_W-1:0] MODE_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] STR_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] CONF_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] MON_RESET    = 8'h08;
  localparam logic [DATA_W-1:0] MDATA_RESET  = 8'hFF;
  localparam logic [DATA_W-1:0] MOVE_RESET   = 8'h00;
  // field positions
  localparam logic [1:0] RSS_STROBE = 2'h1;
  localparam int MODE_RSS_LSB = 0;
  localparam int MODE_RST_LVL = 2;
  localparam int STR_EN_BASE  = 4;
  localparam int STR_EN_NEXT  = 5;
  localparam int STR_EN_THIRD = 6;
  localparam int CONF_GATE_A  = 0;
  localparam int CONF_GATE_B  = 1;
  localparam int MON_MCS_LSB  = 0;
  localparam int MON_DIR      = 2;
  localparam int MON_EN       = 3;
  localparam int MOVE_LINE    = 4;
  localparam int MOVE_EN      = 7;

  // slot arithmetic modulo the frame
  function automatic logic [SLOT_W-1:0] slot_add(input logic [SLOT_W-1:0] s, input logic [SLOT_W-1:0] n);
    logic [SLOT_W:0] sum;
    sum = {1'b0, s} + {1'b0, n};
    if (sum >= (SLOT_W+1)'(SLOTS_PER_FRAME))
      sum = sum - (SLOT_W+1)'(SLOTS_PER_FRAME);
    return sum[SLOT_W-1:0];
  endfunction
endpackage

// File: tss_strobe.sv
// one slot strobe or gated bit clock generator
// assumes tick pulses one cycle after the position counter moves
`timescale 1ns/10ps
`default_nettype none
module tss_strobe (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  // frame position
  input  wire logic                         tick,
  input  wire logic                         framed,
  input  wire logic                         bclk_level,
  input  wire logic [tss_pkg::SLOT_W-1:0]   slot,
  input  wire logic [tss_pkg::BIT_W-1:0]    bit_idx,
  // control
  input  wire logic [tss_pkg::DATA_W-1:0]   ctrl,
  input  wire logic                         gated,
  // output
  output logic                              strobe
);
  import tss_pkg::*;
  logic                window;
  logic                next_window;
  logic                next_strobe;
  logic [SLOT_W-1:0]   base;
  assign base = ctrl[SLOT_W-1:0];

  always_comb begin
    next_window = window;
    // window only moves on tick, so it opens and closes on bit boundaries
    if (tick) begin
      next_window = framed & ((ctrl[STR_EN_BASE] & (slot == base)) |
                              (ctrl[STR_EN_NEXT] & (slot == slot_add(base, NEXT_OFS))) |
                              (ctrl[STR_EN_THIRD] & (slot == slot_add(base, THIRD_OFS)) &
                               (bit_idx < THIRD_BITS)));
    end
    // bclk_level is aligned with tick so no sliver leaks past the window edge
    next_strobe = gated ? (next_window & bclk_level) : next_window;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      window <= 1'b0;
      strobe <= 1'b0;
    end else begin
      window <= next_window;
      strobe <= next_strobe;
    end
  end

  property p_low_outside;
    @(posedge ref_clk) disable iff (rst) !window |-> !strobe;
  endproperty
  a_low_outside: assert property (p_low_outside) else $error("strobe high outside window");
  property p_gate_low;
    @(posedge ref_clk) disable iff (rst) (gated && !bclk_level) |=> !strobe;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gated clock high while bit clock low");
  property p_base_on;
    @(posedge ref_clk) disable iff (rst) (tick && framed && ctrl[STR_EN_BASE] && slot == base) |=> window;
  endproperty
  a_base_on: assert property (p_base_on) else $error("base slot window missing");
  property p_third_short;
    @(posedge ref_clk) disable iff (rst)
      (tick && ctrl[STR_EN_THIRD] && !ctrl[STR_EN_BASE] && !ctrl[STR_EN_NEXT] &&
       slot == slot_add(base, THIRD_OFS) && bit_idx == THIRD_BITS) |=> !window;
  endproperty
  a_third_short: assert property (p_third_short) else $error("third slot strobe too long");
endmodule
`default_nettype wire

// File: tss_slot_mover.sv
// captures one slot from a line and replays it into a target slot
// assumes sample pulses on the bit clock fall, tick after the counter moves
`timescale 1ns/10ps
`default_nettype none
module tss_slot_mover (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  // frame position and line bits
  input  wire logic                         sample,
  input  wire logic                         tick,
  input  wire logic                         framed,
  input  wire logic                         du_bit,
  input  wire logic                         dd_bit,
  input  wire logic [tss_pkg::SLOT_W-1:0]   slot,
  input  wire logic [tss_pkg::BIT_W-1:0]    bit_idx,
  // control
  input  wire logic [tss_pkg::DATA_W-1:0]   src_ctrl,
  input  wire logic [tss_pkg::DATA_W-1:0]   dst_ctrl,
  // results
  output logic [tss_pkg::DATA_W-1:0]        cap_byte,
  output logic                              active,
  output logic                              drive_bit
);
  import tss_pkg::*;
  logic [DATA_W-1:0] shift;
  logic [DATA_W-1:0] out_byte;
  logic [DATA_W-1:0] next_shift;
  logic [DATA_W-1:0] next_cap;
  logic [DATA_W-1:0] next_out;
  logic              src_bit;
  logic              enabled;
  logic [SLOT_W-1:0] src_slot;
  logic [SLOT_W-1:0] dst_slot;
  assign enabled  = src_ctrl[MOVE_EN] & framed;
  assign src_slot = src_ctrl[SLOT_W-1:0];
  assign dst_slot = dst_ctrl[SLOT_W-1:0];
  assign src_bit  = src_ctrl[MOVE_LINE] ? dd_bit : du_bit;

  always_comb begin
    next_shift = shift;
    next_cap   = cap_byte;
    next_out   = out_byte;
    if (sample) begin
      next_shift = {shift[DATA_W-2:0], src_bit};
      if (enabled && slot == src_slot && bit_idx == BIT_LAST)
        next_cap = {shift[DATA_W-2:0], src_bit};
    end
    // hand over two slots after capture: b >= a+2 same frame, else next frame
    if (tick && bit_idx == '0 && slot == slot_add(src_slot, LOAD_GAP))
      next_out = cap_byte;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift    <= '0;
      cap_byte <= '0;
      out_byte <= MDATA_RESET;
    end else begin
      shift    <= next_shift;
      cap_byte <= next_cap;
      out_byte <= next_out;
    end
  end

  assign active    = enabled & (slot == dst_slot);
  // read the byte being handed over, else slot a+2 would open with a stale bit
  assign drive_bit = next_out[BIT_LAST - bit_idx];

  property p_handover;
    @(posedge ref_clk) disable iff (rst)
      (tick && bit_idx == '0 && slot == slot_add(src_slot, LOAD_GAP)) |=> out_byte == $past(cap_byte);
  endproperty
  a_handover: assert property (p_handover) else $error("captured byte not handed over");
endmodule
`default_nettype wire

// File: tss_top.sv
// slot access logic: slot mover, two strobes, monitor channel placement
// assumes async backplane pins and a one-cycle register port on ref_clk
// Behaviour
// - looped slot reappears downstream one frame later
// - shift to slot a+2 or later: same frame
// - shift to a+1 or earlier: next frame
// - two independent programmable slot strobe outputs
// - second strobe shares reset pin, select 01
// - each pin: strobe or gated bit clock
// - strobes every frame from own control register
// - enables for base, next and third slot
// - base and next eight bits, third two
// - gated clock only in window, else low
// - channel select places monitor data
// - direction bit picks upstream or downstream line
// - enable bit turns monitor data on/off
// - reset: channel zero, enabled, downstream
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module tss_top (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  // backplane pins, asynchronous
  input  wire logic                         bit_clk,
  input  wire logic                         frame_sync,
  input  wire logic                         du_in,
  input  wire logic                         dd_in,
  // line drive, enable high while driving
  output logic                              du_out,
  output logic                              du_oe,
  output logic                              dd_out,
  output logic                              dd_oe,
  // strobe pins
  output logic                              strobe_out_a,
  output logic                              strobe_out_b,
  // register port
  input  wire logic [tss_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [tss_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [tss_pkg::DATA_W-1:0]        reg_rdata
);
  import tss_pkg::*;

  logic [3:0]        sync1;
  logic [3:0]        sync2;
  logic              bclk_d;
  logic              fs_d;
  logic              bclk_rise;
  logic              bclk_fall;
  logic              fs_rise;
  logic              frame_start;
  logic              tick;
  logic              fs_pend;
  logic              framed;
  logic [CNT_W-1:0]  bit_count;
  logic              next_fs_pend;
  logic              next_framed;
  logic [CNT_W-1:0]  next_count;
  logic [SLOT_W-1:0] slot;
  logic [BIT_W-1:0]  bit_idx;
  logic [DATA_W-1:0] first_mode_register;
  logic [DATA_W-1:0] strobe_ctrl_a;
  logic [DATA_W-1:0] strobe_ctrl_b;
  logic [DATA_W-1:0] strobe_config_register;
  logic [DATA_W-1:0] monitor_control_register;
  logic [DATA_W-1:0] monitor_data;
  logic [DATA_W-1:0] move_src;
  logic [DATA_W-1:0] move_dst;
  logic [DATA_W-1:0] next_mode;
  logic [DATA_W-1:0] next_str_a;
  logic [DATA_W-1:0] next_str_b;
  logic [DATA_W-1:0] next_conf;
  logic [DATA_W-1:0] next_mon;
  logic [DATA_W-1:0] next_mdata;
  logic [DATA_W-1:0] next_src;
  logic [DATA_W-1:0] next_dst;
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] channel_access_register;
  logic              move_active;
  logic              move_bit;
  logic              win_a;
  logic              win_b;
  logic              mon_hit;
  logic [SLOT_W-1:0] mon_slot;
  logic              next_du_out;
  logic              next_du_oe;
  logic              next_dd_out;
  logic              next_dd_oe;
  logic              next_pin_a;
  logic              next_pin_b;

  // pins pass two flops; edge detection compares the second stage with a third flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1  <= '0;
      sync2  <= '0;
      bclk_d <= 1'b0;
      fs_d   <= 1'b0;
      tick   <= 1'b0;
    end else begin
      sync1  <= {dd_in, du_in, frame_sync, bit_clk};
      sync2  <= sync1;
      bclk_d <= sync2[0];
      fs_d   <= sync2[1];
      tick   <= bclk_rise;
    end
  end

  assign bclk_rise   = sync2[0] & ~bclk_d;
  assign bclk_fall   = ~sync2[0] & bclk_d;
  assign fs_rise     = sync2[1] & ~fs_d;
  assign frame_start = bclk_rise & (fs_pend | fs_rise);
  assign slot        = bit_count[CNT_W-1:BIT_W];
  assign bit_idx     = bit_count[BIT_W-1:0];

  // frame position counts bit clock rises, restarted by frame sync
  always_comb begin
    next_fs_pend = fs_pend;
    next_framed  = framed;
    next_count   = bit_count;
    if (bclk_rise) begin
      next_fs_pend = 1'b0;
      if (frame_start) begin
        next_count  = '0;
        next_framed = 1'b1;
      end else if (bit_count == FRAME_LAST) begin
        next_count = '0;
      end else begin
        next_count = bit_count + 1'b1;
      end
    end else if (fs_rise) begin
      next_fs_pend = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fs_pend   <= 1'b0;
      framed    <= 1'b0;
      bit_count <= '0;
    end else begin
      fs_pend   <= next_fs_pend;
      framed    <= next_framed;
      bit_count <= next_count;
    end
  end

  // register file
  always_comb begin
    next_mode  = first_mode_register;
    next_str_a = strobe_ctrl_a;
    next_str_b = strobe_ctrl_b;
    next_conf  = strobe_config_register;
    next_mon   = monitor_control_register;
    next_mdata = monitor_data;
    next_src   = move_src;
    next_dst   = move_dst;
    next_rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        REG_MODE:     next_mode  = reg_wdata;
        REG_STR_A:    next_str_a = reg_wdata;
        REG_STR_B:    next_str_b = reg_wdata;
        REG_STR_CONF: next_conf  = reg_wdata;
        REG_MON_CTRL: next_mon   = reg_wdata;
        REG_MON_DATA: next_mdata = reg_wdata;
        REG_MOVE_SRC: next_src   = reg_wdata;
        REG_MOVE_DST: next_dst   = reg_wdata;
        default:      next_mode  = first_mode_register;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_MODE:     next_rdata = first_mode_register;
        REG_STR_A:    next_rdata = strobe_ctrl_a;
        REG_STR_B:    next_rdata = strobe_ctrl_b;
        REG_STR_CONF: next_rdata = strobe_config_register;
        REG_MON_CTRL: next_rdata = monitor_control_register;
        REG_MON_DATA: next_rdata = monitor_data;
        REG_MOVE_SRC: next_rdata = move_src;
        REG_MOVE_DST: next_rdata = move_dst;
        REG_ACCESS:   next_rdata = channel_access_register;
        REG_POSITION: next_rdata = {framed, 3'h0, slot};
        default:      next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      first_mode_register      <= MODE_RESET;
      strobe_ctrl_a            <= STR_RESET;
      strobe_ctrl_b            <= STR_RESET;
      strobe_config_register   <= CONF_RESET;
      monitor_control_register <= MON_RESET;
      monitor_data             <= MDATA_RESET;
      move_src                 <= MOVE_RESET;
      move_dst                 <= MOVE_RESET;
      reg_rdata                <= '0;
    end else begin
      first_mode_register      <= next_mode;
      strobe_ctrl_a            <= next_str_a;
      strobe_ctrl_b            <= next_str_b;
      strobe_config_register   <= next_conf;
      monitor_control_register <= next_mon;
      monitor_data             <= next_mdata;
      move_src                 <= next_src;
      move_dst                 <= next_dst;
      reg_rdata                <= next_rdata;
    end
  end

  tss_slot_mover u_mover (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .sample    (bclk_fall),
    .tick      (tick),
    .framed    (framed),
    .du_bit    (sync2[2]),
    .dd_bit    (sync2[3]),
    .slot      (slot),
    .bit_idx   (bit_idx),
    .src_ctrl  (move_src),
    .dst_ctrl  (move_dst),
    .cap_byte  (channel_access_register),
    .active    (move_active),
    .drive_bit (move_bit)
  );

  // two instances, each from its own control register
  tss_strobe u_strobe_a (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .tick       (tick),
    .framed     (framed),
    .bclk_level (bclk_d),
    .slot       (slot),
    .bit_idx    (bit_idx),
    .ctrl       (strobe_ctrl_a),
    .gated      (strobe_config_register[CONF_GATE_A]),
    .strobe     (win_a)
  );

  tss_strobe u_strobe_b (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .tick       (tick),
    .framed     (framed),
    .bclk_level (bclk_d),
    .slot       (slot),
    .bit_idx    (bit_idx),
    .ctrl       (strobe_ctrl_b),
    .gated      (strobe_config_register[CONF_GATE_B]),
    .strobe     (win_b)
  );

  // monitor slot is the third slot of the selected channel
  assign mon_slot = slot_add(MON_IN_CH, SLOT_W'(SLOTS_PER_CH * monitor_control_register[MON_MCS_LSB +: 2]));
  assign mon_hit  = framed & monitor_control_register[MON_EN] & (slot == mon_slot);

  // lines released high when idle; mover wins over monitor if both aim at a bit
  always_comb begin
    next_du_out = du_out;
    next_du_oe  = du_oe;
    next_dd_out = dd_out;
    next_dd_oe  = dd_oe;
    if (tick) begin
      next_du_out = 1'b1;
      next_du_oe  = 1'b0;
      next_dd_out = 1'b1;
      next_dd_oe  = 1'b0;
      if (mon_hit) begin
        if (monitor_control_register[MON_DIR]) begin
          next_du_oe  = 1'b1;
          next_du_out = monitor_data[BIT_LAST - bit_idx];
        end else begin
          next_dd_oe  = 1'b1;
          next_dd_out = monitor_data[BIT_LAST - bit_idx];
        end
      end
      if (move_active) begin
        if (move_dst[MOVE_LINE]) begin
          next_dd_oe  = 1'b1;
          next_dd_out = move_bit;
        end else begin
          next_du_oe  = 1'b1;
          next_du_out = move_bit;
        end
      end
    end
    next_pin_a = win_a;
    next_pin_b = (first_mode_register[MODE_RSS_LSB +: 2] == RSS_STROBE) ?
                 win_b : first_mode_register[MODE_RST_LVL];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      du_out       <= 1'b1;
      du_oe        <= 1'b0;
      dd_out       <= 1'b1;
      dd_oe        <= 1'b0;
      strobe_out_a <= 1'b0;
      strobe_out_b <= 1'b0;
    end else begin
      du_out       <= next_du_out;
      du_oe        <= next_du_oe;
      dd_out       <= next_dd_out;
      dd_oe        <= next_dd_oe;
      strobe_out_a <= next_pin_a;
      strobe_out_b <= next_pin_b;
    end
  end

  property p_frame_wrap;
    @(posedge ref_clk) disable iff (rst) (bclk_rise && !frame_start && bit_count == FRAME_LAST) |=> bit_count == '0;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame counter did not wrap");
  property p_mon_reset;
    @(posedge ref_clk) disable iff (rst) $fell(rst) |-> monitor_control_register == MON_RESET;
  endproperty
  a_mon_reset: assert property (p_mon_reset) else $error("monitor control reset value wrong");
  property p_pin_b_reset;
    @(posedge ref_clk) disable iff (rst)
      (first_mode_register[MODE_RSS_LSB +: 2] != RSS_STROBE) |=> strobe_out_b == $past(first_mode_register[MODE_RST_LVL]);
  endproperty
  a_pin_b_reset: assert property (p_pin_b_reset) else $error("shared pin not showing reset output");
  property p_mon_dd;
    @(posedge ref_clk) disable iff (rst)
      (tick && mon_hit && !monitor_control_register[MON_DIR] && !move_active)
      |=> dd_oe && dd_out == $past(monitor_data[BIT_LAST - bit_idx]) ##1 dd_oe;
  endproperty
  a_mon_dd: assert property (p_mon_dd) else $error("monitor bit not on downstream line");
  property p_mon_off;
    @(posedge ref_clk) disable iff (rst)
      (tick && !monitor_control_register[MON_EN] && !move_active) |=> !du_oe && !dd_oe;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("line driven with monitor disabled");
  property p_lines_hold;
    @(posedge ref_clk) disable iff (rst) !$past(tick) |-> $stable(dd_oe) && $stable(du_oe);
  endproperty
  a_lines_hold: assert property (p_lines_hold) else $error("line changed between bit boundaries");

  c_frame:   cover property (@(posedge ref_clk) disable iff (rst) frame_start ##1 framed);
  c_move:    cover property (@(posedge ref_clk) disable iff (rst) tick && move_active);
  c_strobe:  cover property (@(posedge ref_clk) disable iff (rst) $rose(strobe_out_a));
  c_mon_up:  cover property (@(posedge ref_clk) disable iff (rst) du_oe && monitor_control_register[MON_DIR]);
endmodule
`default_nettype wire

// File: tss_bus_model.sv
// backplane peer: free running bit clock, frame sync, upstream slot data
// assumes the device samples lines at bit clock fall
`timescale 1ns/10ps
`default_nettype none
module tss_bus_model (
  // backplane
  output logic       bit_clk,
  output logic       frame_sync,
  output wire logic  du_in,
  output wire logic  dd_in,
  // device drive
  input  wire logic  du_out,
  input  wire logic  du_oe,
  input  wire logic  dd_out,
  input  wire logic  dd_oe,
  // position
  output int         frame_no,
  output logic [3:0] slot_no,
  output logic [2:0] bit_no
);
  logic [7:0] pat;
  // pulled up; du is wired-and with the peer pattern, a released dd reads 1
  assign du_in = pat[~bit_no] & (du_oe ? du_out : 1'b1);
  assign dd_in = dd_oe ? dd_out : 1'b1;
  initial begin
    {bit_clk, frame_sync, slot_no, bit_no} = '0;
    frame_no = 0;
    pat = 8'hFF;
    forever for (int k = 0; k < 96; k++) begin
      #31 frame_sync = (k == 0);
      #31.5 bit_clk = 1'b1;
      frame_no += (k == 0);
      slot_no = 4'(k / 8);
      bit_no = 3'(k % 8);
      pat = 8'(frame_no * 37 + k / 8 * 11 + 90);
      #31 frame_sync = 1'b0;
      #31.5 bit_clk = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: test_tss_top.sv
// bench for the slot access block: registers, monitor, strobes, mover
// assumes tss_bus_model supplies bit clock, frame sync and slot data
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module test_tss_top;
  import tss_pkg::*;
  logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = '0, sl;
  logic [7:0] reg_wdata = '0, reg_rdata, sdu, sdd, gdu[12], gdd[12];
  logic [1:0] goe[12], oe = '0;
  logic [2:0] bt;
  logic bit_clk, frame_sync, du_in, dd_in, du_out, du_oe, dd_out, dd_oe, sa, sb;
  int mismatches = 0, tests_run = 0, cyc = 0, fr, gfr[12], na = 0, nb = 0, ca, rb, a, b;
  tss_top dut_u (.ref_clk(ref_clk), .rst(rst), .bit_clk(bit_clk), .frame_sync(frame_sync),
    .du_in(du_in), .dd_in(dd_in), .du_out(du_out), .du_oe(du_oe), .dd_out(dd_out), .dd_oe(dd_oe),
    .strobe_out_a(sa), .strobe_out_b(sb), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  tss_bus_model peer_u (.bit_clk(bit_clk), .frame_sync(frame_sync), .du_in(du_in), .dd_in(dd_in),
    .du_out(du_out), .du_oe(du_oe), .dd_out(dd_out), .dd_oe(dd_oe), .frame_no(fr), .slot_no(sl), .bit_no(bt));
  always #5 ref_clk = ~ref_clk;
  function automatic logic [7:0] pat(input int f, input int s);
    return 8'(f * 37 + s * 11 + 90);
  endfunction
  // gather each slot as seen on the pins, msb first
  always @(negedge bit_clk) begin
    sdu = {sdu[6:0], du_out};
    sdd = {sdd[6:0], dd_out};
    oe |= {du_oe, dd_oe};
    na += sa;
    if (bt == 3'h7) begin
      gdu[sl] = sdu;
      gdd[sl] = sdd;
      goe[sl] = oe;
      gfr[sl] = fr;
      oe = '0;
      if (sl == 4'hB) begin
        ca = na;
        rb = nb;
        na = 0;
        nb = 0;
      end
    end
  end
  always @(posedge sb) nb++;
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge ref_clk) begin reg_addr <= ad; reg_wdata <= d; reg_wr <= 1'b1; end
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [7:0] e);
    @(posedge ref_clk) begin reg_addr <= ad; reg_rd <= 1'b1; end
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic wf(input int n);
    repeat (n) @(posedge frame_sync);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // about 40 frames of 1200 cycles are needed
  always @(posedge ref_clk) if (++cyc == 90000) begin mismatches++; summarize; end
  initial begin
    a = $urandom(79626);
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(REG_MON_CTRL, MON_RESET);
    rd(REG_MODE, MODE_RESET);
    rd(REG_STR_B, STR_RESET);
    rd(REG_MON_DATA, MDATA_RESET);
    rd(4'hF, 8'h00);
    wf(3);
    `CHK("mon_dflt", 8'hFF, gdd[2])
    `CHK("mon_dflt_oe", 2'h1, goe[2])
    // channels 0 to 2 on both lines
    for (int m = 0; m < 6; m++) begin
      b = $urandom % 256;
      wr(REG_MON_DATA, 8'(b));
      wr(REG_MON_CTRL, 8'(8 + m / 3 * 4 + m % 3));
      wf(2);
      a = 4 * (m % 3) + 2;
      `CHK("mon_byte", 8'(b), m > 2 ? gdu[a] : gdd[a])
      `CHK("mon_oe", m > 2 ? 2'h2 : 2'h1, goe[a])
    end
    wr(REG_MON_CTRL, 8'h00);
    wf(2);
    `CHK("mon_off", 2'h0, goe[2] | goe[6] | goe[10])
    wr(REG_MODE, 8'h04);
    repeat (20) @(posedge ref_clk);
    `CHK("pin_b_reset_lvl", 1'b1, sb)
    wr(REG_MODE, 8'(RSS_STROBE));
    wr(REG_STR_CONF, 8'h02);
    // each nonzero enable combination, A as strobe, B as gated clock
    for (int e = 1; e < 8; e++) begin
      wr(REG_STR_A, 8'(e * 16 + $urandom % 9));
      wr(REG_STR_B, 8'(e * 16 + $urandom % 9));
      wf(2);
      `CHK("strobe_a_bits", 8 * e[0] + 8 * e[1] + 2 * e[2], ca)
      `CHK("gated_b_pulses", 8 * e[0] + 8 * e[1] + 2 * e[2], rb)
    end
    // loop to downstream, then shifts to a+2, a+1 and an earlier slot
    for (int t = 0; t < 4; t++) begin
      a = 1 + $urandom % 9;
      b = t == 0 ? a : t == 1 ? a + 2 : t == 2 ? a + 1 : $urandom % a;
      wr(REG_MOVE_SRC, 8'h80 | 8'(a));
      wr(REG_MOVE_DST, 8'((t == 0) * 16 + b));
      wf(3);
      `CHK("moved_byte", pat(gfr[b] - (t != 1), a), t == 0 ? gdd[b] : gdu[b])
      rd(REG_ACCESS, pat(gfr[b], a));
    end
    summarize;
  end
endmodule
`default_nettype wire
